// [pkg/charger_supervisor_regs.svh]
// register map, field positions, reset values and timing counts of the
// charger supervisor; assumes an APB slave with 32-bit aligned words
`ifndef CHARGER_SUPERVISOR_REGS_SVH
`define CHARGER_SUPERVISOR_REGS_SVH

`define CTRL_ADDR 12'h000
`define STATUS_ADDR 12'h004
`define EVENT_ADDR 12'h008
`define MASK_ADDR 12'h00c
`define STRAP_ADDR 12'h010

`define CTRL_CHG_OFF 0
`define CTRL_USB_OFF 1
`define CTRL_USB_HIGH 2
`define CTRL_RESET 32'h0000_0000

`define EV_FAULT 0
`define EV_TERM 1
`define EV_RAIL_LOW 2
`define EV_POWER_FAIL 3
`define EV_WIDTH 4

`define MAIN_MV_LOW 16'd3000
`define MAIN_MV_HIGH 16'd3300
`define CORE_MV_LOW 16'd1500
`define CORE_MV_HIGH 16'd1800
`define USB_MA_LOW 10'd100
`define USB_MA_HIGH 10'd500

`define USB_DELAY_CYCLES 32'd200000
`define STRAP_SETTLE 2'd2

`endif

// [pkg/charger_supervisor_pkg.sv]
// types shared by the charger supervisor files
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package charger_supervisor_pkg;
    typedef enum logic [1:0] {src_none, src_adapter, src_usb} source_type;

    typedef enum {chg_idle, chg_usb_wait, chg_on, chg_suspend} charge_state_type;

    // analog comparator results as they come off the pins
    typedef struct packed {
        logic adapter_valid;
        logic adapter_over;
        logic usb_valid;
        logic battery_low;
        logic over_temp_warn;
        logic cover_present;
        logic temp_above_low;
        logic temp_below_high;
        logic charge_fault;
        logic charge_done;
        logic rail_low;
    } sense_type;

    typedef struct packed {
        logic main_rail_default_select;
        logic core_rail_default_select;
        logic address_low_bit_select;
    } strap_type;
endpackage
`default_nettype wire

// [core/sense_sync.sv]
// two-flop synchroniser for a vector of asynchronous levels
// assumes inputs are quasi-static relative to sys_clk
`default_nettype none
module sense_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// [core/usb_start_delay.sv]
// counts a settle delay after usb becomes valid before charge may start
// assumes a synchronised request level
`default_nettype none
module usb_start_delay #(
    parameter int unsigned CYCLES = 200000
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic request,
    output logic done
);
    logic [31:0] count_ff;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            count_ff <= 32'h0000_0000;
            done <= 1'b0;
        end
        else if (!request)
        begin
            count_ff <= 32'h0000_0000;
            done <= 1'b0;
        end
        else if (count_ff >= CYCLES - 1)
        begin
            done <= 1'b1;
        end
        else
        begin
            count_ff <= count_ff + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// [core/charger_supervisor.sv]
// control logic of the single-cell charger and supervisor
// assumes comparator outputs and straps arrive asynchronously on pins
//
// The implementer's own choices: register access over APB and the register addresses.
`include "charger_supervisor_regs.svh"
`default_nettype none
module charger_supervisor
    import charger_supervisor_pkg::*;
#(
    parameter int unsigned USB_DELAY = `USB_DELAY_CYCLES,
    parameter logic core_sleep_disable = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sense_type sense_pin,
    input wire strap_type strap_pin,
    input wire logic deep_sleep_request,
    output logic power_fail_n,
    output logic event_flag_n,
    output logic power_switch_on,
    output logic charge_timer_run,
    output source_type charge_source,
    output logic [9:0] usb_limit_ma,
    output logic [15:0] main_rail_mv,
    output logic [15:0] core_rail_mv,
    output logic core_rail_enable,
    output logic address_low_bit,
    output logic irq
);
    // ************************************************************
    // synchronisers
    // ************************************************************
    sense_type sense;
    strap_type strap;
    logic sleep_sync;

    sense_sync #(.WIDTH($bits(sense_type) + $bits(strap_type) + 1)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({sense_pin, strap_pin, deep_sleep_request}),
        .sync_out({sense, strap, sleep_sync})
    );

    // ************************************************************
    // register bus
    // ************************************************************
    logic [31:0] ctrl_ff;
    logic [`EV_WIDTH-1:0] event_ff;
    logic [`EV_WIDTH-1:0] mask_ff;
    logic strap_taken_ff;
    logic [1:0] strap_wait_ff;
    strap_type strap_ff;
    charge_state_type state_ff;
    logic [`EV_WIDTH-1:0] ev_pulse;
    logic [`EV_WIDTH-1:0] ev_level_ff;
    logic [`EV_WIDTH-1:0] ev_level;
    logic bus_setup;
    logic bus_write;

    assign bus_setup = psel && !penable;
    assign bus_write = psel && penable && pready && pwrite;

    function automatic logic addr_known(input logic [11:0] a);
        return a == `CTRL_ADDR || a == `STATUS_ADDR || a == `EVENT_ADDR
            || a == `MASK_ADDR || a == `STRAP_ADDR;
    endfunction

    // no wait state: ready rises the cycle after setup
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= bus_setup;
            pslverr <= bus_setup && !addr_known(paddr);
            if (bus_setup && !pwrite)
            begin
                case (paddr)
                    `CTRL_ADDR: prdata <= ctrl_ff;
                    `STATUS_ADDR: prdata <= {25'h0, state_ff == chg_suspend,
                        charge_source, power_switch_on, core_rail_enable,
                        power_fail_n, event_flag_n};
                    `EVENT_ADDR: prdata <= {28'h0, event_ff};
                    `MASK_ADDR: prdata <= {28'h0, mask_ff};
                    `STRAP_ADDR: prdata <= {29'h0, strap_ff};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_ff <= `CTRL_RESET;
        end
        else if (bus_write && paddr == `CTRL_ADDR)
        begin
            ctrl_ff <= {29'h0, pwdata[2:0]};
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            mask_ff <= '0;
        end
        else if (bus_write && paddr == `MASK_ADDR)
        begin
            mask_ff <= pwdata[`EV_WIDTH-1:0];
        end
    end

    // ************************************************************
    // straps
    // ************************************************************
    // caught once after reset release, never from the reset branch
    // waits until the synchroniser has flushed its reset zeros
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            strap_wait_ff <= 2'd0;
            strap_taken_ff <= 1'b0;
            strap_ff <= '0;
        end
        else if (strap_wait_ff != `STRAP_SETTLE)
        begin
            strap_wait_ff <= strap_wait_ff + 2'd1;
        end
        else if (!strap_taken_ff)
        begin
            strap_taken_ff <= 1'b1;
            strap_ff <= strap;
        end
    end

    // ************************************************************
    // charge source and state
    // ************************************************************
    logic adapter_ok;
    logic usb_ok;
    logic temp_ok;
    logic usb_wait_done;
    logic chg_off;
    charge_state_type nxt_state;
    source_type nxt_source;

    assign adapter_ok = sense.adapter_valid && !sense.adapter_over;
    assign chg_off = ctrl_ff[`CTRL_CHG_OFF];
    assign usb_ok = sense.usb_valid && !ctrl_ff[`CTRL_USB_OFF];
    assign temp_ok = sense.temp_above_low && sense.temp_below_high;

    usb_start_delay #(.CYCLES(USB_DELAY)) u_delay (
        .sys_clk(sys_clk),
        .rst(rst),
        .request(usb_ok && !adapter_ok && !chg_off),
        .done(usb_wait_done)
    );

    always_comb
    begin
        nxt_source = src_none;
        if (!chg_off && adapter_ok)
            nxt_source = src_adapter;
        else if (!chg_off && usb_ok)
            nxt_source = src_usb;
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            chg_idle:
                if (nxt_source == src_adapter)
                    nxt_state = temp_ok ? chg_on : chg_suspend;
                else if (nxt_source == src_usb)
                    nxt_state = chg_usb_wait;
            chg_usb_wait:
                if (nxt_source == src_adapter)
                    nxt_state = temp_ok ? chg_on : chg_suspend;
                else if (nxt_source != src_usb)
                    nxt_state = chg_idle;
                else if (usb_wait_done)
                    nxt_state = temp_ok ? chg_on : chg_suspend;
            chg_on:
                if (nxt_source == src_none)
                    nxt_state = chg_idle;
                else if (nxt_source == src_usb && !usb_wait_done)
                    nxt_state = chg_usb_wait;
                else if (!temp_ok)
                    nxt_state = chg_suspend;
            chg_suspend:
                if (nxt_source == src_none)
                    nxt_state = chg_idle;
                else if (nxt_source == src_usb && !usb_wait_done)
                    nxt_state = chg_usb_wait;
                else if (temp_ok)
                    nxt_state = chg_on;
            default: nxt_state = chg_idle;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= chg_idle;
            charge_source <= src_none;
            power_switch_on <= 1'b0;
            charge_timer_run <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            charge_source <= nxt_state == chg_idle ? src_none : nxt_source;
            power_switch_on <= nxt_state == chg_on;
            charge_timer_run <= nxt_state == chg_on;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            usb_limit_ma <= `USB_MA_LOW;
        else
            usb_limit_ma <= ctrl_ff[`CTRL_USB_HIGH] ? `USB_MA_HIGH : `USB_MA_LOW;
    end

    // ************************************************************
    // rails and address
    // ************************************************************
    // main rail default
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            main_rail_mv <= `MAIN_MV_LOW;
            core_rail_mv <= `CORE_MV_LOW;
            core_rail_enable <= 1'b0;
            address_low_bit <= 1'b0;
        end
        else
        begin
            main_rail_mv <= strap_ff.main_rail_default_select ? `MAIN_MV_HIGH
                : `MAIN_MV_LOW;
            core_rail_mv <= (sleep_sync || !strap_ff.core_rail_default_select)
                ? `CORE_MV_LOW : `CORE_MV_HIGH;
            core_rail_enable <= strap_taken_ff && !(sleep_sync && core_sleep_disable);
            address_low_bit <= strap_ff.address_low_bit_select;
        end
    end

    // ************************************************************
    // supervisor outputs and events
    // ************************************************************
    always_comb
    begin
        ev_level = '0;
        ev_level[`EV_FAULT] = sense.charge_fault;
        ev_level[`EV_TERM] = sense.charge_done;
        ev_level[`EV_RAIL_LOW] = sense.rail_low;
        ev_level[`EV_POWER_FAIL] = sense.battery_low || sense.over_temp_warn
            || !sense.cover_present;
    end
    // no edges until the synchroniser holds real pin levels
    assign ev_pulse = ev_level & ~ev_level_ff & {`EV_WIDTH{strap_taken_ff}};

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ev_level_ff <= '0;
            power_fail_n <= 1'b1;
            event_flag_n <= 1'b1;
        end
        else
        begin
            ev_level_ff <= ev_level;
            power_fail_n <= !ev_level[`EV_POWER_FAIL];
            event_flag_n <= !(ev_level[`EV_FAULT] || ev_level[`EV_TERM]
                || ev_level[`EV_RAIL_LOW]);
        end
    end

    // set wins over a same-cycle write-one clear
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            event_ff <= '0;
        else if (bus_write && paddr == `EVENT_ADDR)
            event_ff <= (event_ff & ~pwdata[`EV_WIDTH-1:0]) | ev_pulse;
        else
            event_ff <= event_ff | ev_pulse;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(event_ff & mask_ff);
    end

    // ************************************************************
    // checks
    // ************************************************************
    power_fail_a: assert property (@(posedge sys_clk) disable iff (rst)
        !sense.cover_present |=> !power_fail_n)
        else $error("power fail not low on cover removal");
    event_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
        sense.charge_fault |=> !event_flag_n)
        else $error("event flag not low on fault");
    sleep_core_a: assert property (@(posedge sys_clk) disable iff (rst)
        sleep_sync |=> core_rail_mv == `CORE_MV_LOW)
        else $error("core rail not lowered in sleep");
    main_strap_a: assert property (@(posedge sys_clk) disable iff (rst)
        strap_taken_ff && strap_ff.main_rail_default_select |=> main_rail_mv == `MAIN_MV_HIGH)
        else $error("main rail strap ignored");
    core_strap_a: assert property (@(posedge sys_clk) disable iff (rst)
        !sleep_sync && strap_ff.core_rail_default_select |=> core_rail_mv == `CORE_MV_HIGH)
        else $error("core rail strap ignored");
    addr_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 address_low_bit == $past(strap_ff.address_low_bit_select))
        else $error("address bit wrong");
    adapter_first_a: assert property (@(posedge sys_clk) disable iff (rst)
        adapter_ok && !chg_off |=> charge_source == src_adapter)
        else $error("adapter not preferred");
    over_volt_a: assert property (@(posedge sys_clk) disable iff (rst)
        sense.adapter_over && !usb_ok |=> charge_source != src_adapter ##0 !power_switch_on)
        else $error("charging on overvoltage");
    temp_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !temp_ok |=> !power_switch_on && !charge_timer_run)
        else $error("charging out of temperature");
    off_ctrl_a: assert property (@(posedge sys_clk) disable iff (rst)
        chg_off |=> !power_switch_on)
        else $error("charger disable ignored");
    usb_limit_a: assert property (@(posedge sys_clk) disable iff (rst)
        !ctrl_ff[`CTRL_USB_HIGH] |=> usb_limit_ma == `USB_MA_LOW)
        else $error("usb limit raised without host");
    usb_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
        state_ff == chg_idle && nxt_state == chg_usb_wait |=> !power_switch_on [*2])
        else $error("usb charge started without delay");
endmodule
`default_nettype wire

// [sim/host_sleep_model.sv]
// host side model: drives the deep sleep request pin of the supervisor
// assumes the bench states the wanted sleep level on sleep_wanted
`default_nettype none
module host_sleep_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sleep_wanted,
    output logic deep_sleep_request
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            deep_sleep_request <= 1'b0;
        else
            deep_sleep_request <= sleep_wanted;
    end
endmodule
`default_nettype wire

// [sim/charger_supervisor_tb.sv]
// self-checking bench of the charger supervisor control block
// assumes the design files and the package are compiled first
`include "charger_supervisor_regs.svh"
`default_nettype none
module charger_supervisor_tb;
    import charger_supervisor_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int usb_delay = 10;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, power_fail_n, event_flag_n, power_switch_on, charge_timer_run;
    logic core_rail_enable, address_low_bit, irq, sleep_wanted, deep_sleep_request;
    logic [9:0] usb_limit_ma;
    logic [15:0] main_rail_mv, core_rail_mv;
    source_type charge_source;
    sense_type sense = '0;
    strap_type strap = '1;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    charger_supervisor #(.USB_DELAY(usb_delay), .core_sleep_disable(1'b0)) i_charger_supervisor (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sense_pin(sense), .strap_pin(strap), .deep_sleep_request(deep_sleep_request),
        .power_fail_n(power_fail_n), .event_flag_n(event_flag_n),
        .power_switch_on(power_switch_on), .charge_timer_run(charge_timer_run),
        .charge_source(charge_source), .usb_limit_ma(usb_limit_ma),
        .main_rail_mv(main_rail_mv), .core_rail_mv(core_rail_mv),
        .core_rail_enable(core_rail_enable), .address_low_bit(address_low_bit), .irq(irq));

    host_sleep_model i_host_sleep_model (.sys_clk(sys_clk), .rst(rst),
        .sleep_wanted(sleep_wanted), .deep_sleep_request(deep_sleep_request));

    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // sense pins pass two sync flops plus an output flop
    task automatic settle();
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic finish_test();
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_straps();
        chk(main_rail_mv, `MAIN_MV_HIGH);
        chk(core_rail_mv, `CORE_MV_HIGH);
        chk(address_low_bit, 1'b1);
        apb(1'b0, `STRAP_ADDR, 32'h0);
        chk(rd, 32'h7);
        apb(1'b0, `CTRL_ADDR, 32'h0);
        chk(rd, `CTRL_RESET);
        apb(1'b0, 12'h020, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
    endtask

    task automatic t_sources();
        sense.adapter_valid <= 1'b1;
        sense.usb_valid <= 1'b1;
        settle();
        chk({charge_source, power_switch_on, charge_timer_run}, {src_adapter, 2'b11});
        sense.adapter_over <= 1'b1;
        settle();
        chk(power_switch_on, 1'b0);
        repeat (usb_delay + 6) @(posedge sys_clk);
        chk({charge_source, power_switch_on}, {src_usb, 1'b1});
        chk(usb_limit_ma, `USB_MA_LOW);
        apb(1'b1, `CTRL_ADDR, 32'h4);
        @(posedge sys_clk);
        chk(usb_limit_ma, `USB_MA_HIGH);
        sense.adapter_over <= 1'b0;
        settle();
        chk(charge_source, src_adapter);
    endtask

    task automatic t_temp();
        for (int i = 0; i < 2; i++)
        begin
            {sense.temp_above_low, sense.temp_below_high} <= 2'b01 << i;
            settle();
            chk({power_switch_on, charge_timer_run}, 2'b00);
            apb(1'b0, `STATUS_ADDR, 32'h0);
            chk(rd[6], 1'b1);
            {sense.temp_above_low, sense.temp_below_high} <= 2'b11;
            settle();
            chk({power_switch_on, charge_timer_run}, 2'b11);
        end
    endtask

    task automatic t_ctrl();
        apb(1'b1, `CTRL_ADDR, 32'h2);
        sense.adapter_valid <= 1'b0;
        repeat (usb_delay + 10) @(posedge sys_clk);
        chk({charge_source, power_switch_on}, {src_none, 1'b0});
        sense.adapter_valid <= 1'b1;
        apb(1'b1, `CTRL_ADDR, 32'h1);
        settle();
        chk(power_switch_on, 1'b0);
        apb(1'b1, `CTRL_ADDR, 32'h0);
        settle();
        chk(power_switch_on, 1'b1);
    endtask

    task automatic t_flags();
        logic [2:0] pf_pat [3] = '{3'b101, 3'b011, 3'b000};
        sense.cover_present <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            {sense.battery_low, sense.over_temp_warn, sense.cover_present} <= pf_pat[i];
            settle();
            chk(power_fail_n, 1'b0);
            {sense.battery_low, sense.over_temp_warn, sense.cover_present} <= 3'b001;
            {sense.charge_fault, sense.charge_done, sense.rail_low} <= 3'b100 >> i;
            settle();
            chk({power_fail_n, event_flag_n}, 2'b10);
            {sense.charge_fault, sense.charge_done, sense.rail_low} <= 3'b000;
            settle();
            chk({power_fail_n, event_flag_n}, 2'b11);
        end
        apb(1'b0, `EVENT_ADDR, 32'h0);
        chk(irq, 1'b0);
        chk(rd, 32'hf);
        apb(1'b1, `MASK_ADDR, 32'h8);
        @(posedge sys_clk);
        chk(irq, 1'b1);
        apb(1'b1, `EVENT_ADDR, 32'h8);
        apb(1'b0, `EVENT_ADDR, 32'h0);
        chk(irq, 1'b0);
        chk(rd, 32'h7);
    endtask

    task automatic t_sleep();
        sleep_wanted <= 1'b1;
        settle();
        @(posedge sys_clk);
        chk({core_rail_mv, core_rail_enable}, {`CORE_MV_LOW, 1'b1});
        sleep_wanted <= 1'b0;
        settle();
        @(posedge sys_clk);
        chk(core_rail_mv, `CORE_MV_HIGH);
    endtask

    // ****************************************
    // main sequence and hang guard
    // ****************************************
    initial
    begin
        sleep_wanted = 1'b0;
        sense.cover_present = 1'b1;
        sense.temp_above_low = 1'b1;
        sense.temp_below_high = 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        settle();
        settle();
        t_straps();
        t_sources();
        t_temp();
        t_ctrl();
        t_flags();
        t_sleep();
        finish_test();
    end

    // the whole run needs well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            finish_test();
        end
    end
endmodule
`default_nettype wire
